/* File: usi_shifter.v */
// Behaviour
// - one 8-bit shift register holds tx and rx data, received bytes queued in a 32-entry fifo
// - register msb drives one of two output pins chosen by wire mode
// - with external clock, output latch delays pin change to edge opposite the sampling edge
// - serial input always comes from the data-in pin
// - 4-bit counter readable, writable, raises overflow interrupt
// - shift register and counter advance on the same clock source
// - external clock increments counter on both edges
// - clock source: clock pin, timer zero compare match, or software strobe
// - two-wire mode: start flag interrupt, hold clock low after start or overflow
// - three-wire mode is spi mode 0 or 1, no slave select
// - edge select clear: sample and shift on rising, output changes on falling edges
// - edge select set: sample and shift on falling, output changes on rising edges
// - sixteen counted edges overflow counter and set overflow flag
// - overflow interrupt can wake processor from idle sleep
// - status write with flag bit set clears flag, loads counter field
// - each software strobe write shifts one bit and counts once; toggle strobe flips clock pin
// - shifts are left shifts, new bit enters at lsb
// - data write and clock event in one cycle: written value kept
`timescale 1ns/1ns
`include "usi_defs.vh"

module usi_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire core_clk,
    input wire rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_ff;
    reg [AW:0] rd_ptr_ff;
    wire full;
    wire empty;
    wire do_wr;
    wire do_rd;

    // pointer-based full and empty
    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign full = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign do_wr = in_valid && !full;
    assign do_rd = out_ready && !empty;

    // storage write
    always @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    // head word presented combinationally from memory
    always @* begin
        out_data = mem[rd_ptr_ff[AW-1:0]];
    end

    // pointers
    always @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // usi_fifo

module usi_shifter #(
    parameter DATA_W = `USI_DATA_W,
    parameter CNT_W = `USI_CNT_W,
    parameter FIFO_DEPTH = `USI_FIFO_DEPTH,
    parameter FIFO_AW = `USI_FIFO_AW
) (
    input wire core_clk,
    input wire rst,
    // control bits
    input wire [1:0] wire_mode_select,
    input wire clock_source_select,
    input wire clock_edge_select,
    input wire ctrl_wr,
    input wire software_clock_strobe,
    input wire clock_toggle_strobe,
    input wire ovf_int_enable,
    input wire start_int_enable,
    input wire timer0_compare_match,
    // data register access
    input wire data_wr,
    input wire [DATA_W-1:0] data_wdata,
    output wire [DATA_W-1:0] serial_shift_reg,
    // status register access
    input wire status_wr,
    input wire [DATA_W-1:0] status_wdata,
    output wire [DATA_W-1:0] serial_status_reg,
    output wire ovf_irq,
    output wire start_irq,
    output wire idle_wake,
    // received byte stream
    output wire [DATA_W-1:0] rx_data,
    output wire rx_valid,
    input wire rx_ready,
    output wire rx_overrun,
    // pins
    input wire serial_in_pin,
    input wire serial_clock_pin_in,
    output wire serial_clock_pin_out,
    output wire serial_clock_pin_oe,
    input wire port_clock_level,
    input wire port_clock_dir,
    input wire sda_pin_in,
    output wire data_out_pin,
    output wire sda_pin_out,
    output wire sda_pin_oe
);
    // synchronisers for pins
    reg [1:0] sck_sync_ff;
    reg [1:0] din_sync_ff;
    reg [1:0] sda_sync_ff;
    reg sck_prev_ff;
    reg sda_prev_ff;
    // data path, counter and flag state
    reg [DATA_W-1:0] shift_ff;
    reg [CNT_W-1:0] cnt_ff;
    reg out_latch_ff;
    reg ovf_flag_ff;
    reg start_flag_ff;
    reg hold_ff;
    reg toggle_ff;
    reg push_ff;
    reg overrun_ff;
    // decoded pin levels, edges and ticks
    wire sck_lvl;
    wire sck_rise;
    wire sck_fall;
    wire din_lvl;
    wire sda_lvl;
    wire ext_mode;
    wire sample_edge;
    wire change_edge;
    wire shift_tick;
    wire count_tick;
    wire wrap;
    wire soft_tick;
    wire fifo_in_ready;
    wire two_wire;
    wire start_seen;
    wire sck_drive;
    wire sck_hold;

    // two-flop synchronisers
    always @(posedge core_clk) begin
        if (rst) begin
            sck_sync_ff <= 2'h0;
            din_sync_ff <= 2'h0;
            sda_sync_ff <= 2'h3;
        end else begin
            sck_sync_ff <= {sck_sync_ff[0], serial_clock_pin_in};
            din_sync_ff <= {din_sync_ff[0], serial_in_pin};
            sda_sync_ff <= {sda_sync_ff[0], sda_pin_in};
        end
    end

    // previous synchronised levels for edge finding, reset to pin idle levels
    always @(posedge core_clk) begin
        if (rst) begin
            sck_prev_ff <= 1'b0;
            sda_prev_ff <= 1'b1;
        end else begin
            sck_prev_ff <= sck_sync_ff[1];
            sda_prev_ff <= sda_sync_ff[1];
        end
    end

    // synchronised levels and edges
    assign sck_lvl = sck_sync_ff[1];
    assign din_lvl = din_sync_ff[1];
    assign sda_lvl = sda_sync_ff[1];
    assign sck_rise = sck_lvl && !sck_prev_ff;
    assign sck_fall = !sck_lvl && sck_prev_ff;
    assign two_wire = (wire_mode_select == `USI_WM_TWO);

    // clock source selection
    assign ext_mode = (clock_source_select == `USI_SRC_EXT);
    assign soft_tick = ctrl_wr && software_clock_strobe;
    // edge select picks sampling edge, opposite edge moves the output
    assign sample_edge = clock_edge_select ? sck_fall : sck_rise;
    assign change_edge = clock_edge_select ? sck_rise : sck_fall;
    // external: shift on sampling edge; else compare match or software strobe
    assign shift_tick = ext_mode ? sample_edge
        : (clock_edge_select ? soft_tick : timer0_compare_match);
    // counter follows the same source; external counts both edges
    assign count_tick = ext_mode ? (sck_rise || sck_fall)
        : (clock_edge_select ? soft_tick : timer0_compare_match);
    assign wrap = count_tick && (cnt_ff == `USI_CNT_MAX);

    // shift register, write wins over a same-cycle shift
    always @(posedge core_clk) begin
        if (rst) begin
            shift_ff <= {DATA_W{1'b0}};
        end else if (data_wr) begin
            shift_ff <= data_wdata;
        end else if (shift_tick) begin
            shift_ff <= {shift_ff[DATA_W-2:0], din_lvl};
        end
    end

    // output latch: transparent outside external clocking, else follows change edge
    always @(posedge core_clk) begin
        if (rst) begin
            out_latch_ff <= 1'b0;
        end else if (!ext_mode || change_edge || data_wr) begin
            out_latch_ff <= data_wr ? data_wdata[DATA_W-1] : shift_ff[DATA_W-1];
        end
    end

    // counter: status write loads, else one step per counted tick
    always @(posedge core_clk) begin
        if (rst) begin
            cnt_ff <= {CNT_W{1'b0}};
        end else if (status_wr) begin
            cnt_ff <= status_wdata[CNT_W-1:0];
        end else if (count_tick) begin
            cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // overflow flag: set on the wrapping tick, cleared by a status write with bit 6 set
    always @(posedge core_clk) begin
        if (rst) begin
            ovf_flag_ff <= 1'b0;
        end else if (wrap && !status_wr) begin
            ovf_flag_ff <= 1'b1;
        end else if (status_wr && status_wdata[`USI_ST_OVF_BIT]) begin
            ovf_flag_ff <= 1'b0;
        end
    end

    // start detector for two-wire mode
    assign start_seen = two_wire && sck_lvl && sda_prev_ff && !sda_lvl;
    always @(posedge core_clk) begin
        if (rst) begin
            start_flag_ff <= 1'b0;
        end else if (start_seen) begin
            start_flag_ff <= 1'b1;
        end else if (status_wr && status_wdata[`USI_ST_START_BIT]) begin
            start_flag_ff <= 1'b0;
        end
    end

    // clock hold after a start or an overflow, released by a status write
    always @(posedge core_clk) begin
        if (rst) begin
            hold_ff <= 1'b0;
        end else if (two_wire && ((start_flag_ff && sck_fall) || (wrap && !status_wr))) begin
            hold_ff <= 1'b1;
        end else if (status_wr) begin
            hold_ff <= 1'b0;
        end
    end

    // clock toggle strobe flips the driven clock level
    always @(posedge core_clk) begin
        if (rst) begin
            toggle_ff <= 1'b0;
        end else if (ctrl_wr && clock_toggle_strobe) begin
            toggle_ff <= !toggle_ff;
        end
    end

    // received byte copied out one cycle after overflow
    always @(posedge core_clk) begin
        if (rst) begin
            push_ff <= 1'b0;
        end else begin
            push_ff <= wrap && !status_wr;
        end
    end

    // a push refused by a full queue is flagged until cleared
    always @(posedge core_clk) begin
        if (rst) begin
            overrun_ff <= 1'b0;
        end else if (push_ff && !fifo_in_ready) begin
            overrun_ff <= 1'b1;
        end else if (status_wr && status_wdata[`USI_ST_OVF_BIT]) begin
            overrun_ff <= 1'b0;
        end
    end

    // byte queue between shift register and reader
    usi_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_data(shift_ff),
        .in_valid(push_ff),
        .in_ready(fifo_in_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // pin drive: msb goes to data-out or sda per wire mode
    assign data_out_pin = (wire_mode_select == `USI_WM_THREE) ? out_latch_ff : 1'b0;
    assign sda_pin_out = 1'b0;
    assign sda_pin_oe = two_wire && !out_latch_ff;
    assign sck_drive = port_clock_level ^ toggle_ff;
    assign sck_hold = two_wire && hold_ff;
    // clock pin: held low while waiting, else port level xor toggle state
    assign serial_clock_pin_out = sck_hold ? 1'b0 : sck_drive;
    // two-wire clock is open drain: only a low level is actively driven
    assign serial_clock_pin_oe = sck_hold || (port_clock_dir && !(two_wire && sck_drive));

    // readback and interrupts
    assign serial_shift_reg = shift_ff;
    assign serial_status_reg = {start_flag_ff, ovf_flag_ff, overrun_ff, 1'b0, cnt_ff};
    assign ovf_irq = ovf_flag_ff && ovf_int_enable;
    assign start_irq = start_flag_ff && start_int_enable;
    assign idle_wake = ovf_irq;
    // refused pushes are reported until the flag is cleared
    assign rx_overrun = overrun_ff;
endmodule // usi_shifter

/* File: usi_defs.vh */
`ifndef USI_DEFS_VH
`define USI_DEFS_VH
// wire mode encodings
`define USI_WM_NONE 2'h0
`define USI_WM_THREE 2'h1
`define USI_WM_TWO 2'h2
// clock source select encodings, one bit
`define USI_SRC_SOFT 1'h0
`define USI_SRC_EXT 1'h1
// counter width and data width
`define USI_DATA_W 8
`define USI_CNT_W 4
`define USI_CNT_MAX 4'hf
// status write bit positions
`define USI_ST_START_BIT 7
`define USI_ST_OVF_BIT 6
// fifo defaults
`define USI_FIFO_DEPTH 32
`define USI_FIFO_AW 5
`endif

/* File: usi_shifter_sva.sv */
`timescale 1ns/1ns
module usi_shifter_sva (
    input wire core_clk,
    input wire rst,
    input wire [1:0] wire_mode_select,
    input wire clock_source_select,
    input wire ovf_int_enable,
    input wire start_int_enable,
    input wire data_wr,
    input wire [7:0] data_wdata,
    input wire [7:0] serial_shift_reg,
    input wire status_wr,
    input wire [7:0] status_wdata,
    input wire [7:0] serial_status_reg,
    input wire ovf_irq,
    input wire start_irq,
    input wire rx_valid,
    input wire serial_clock_pin_in,
    input wire data_out_pin
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // counter and overflow flag fields
    wire [3:0] cnt = serial_status_reg[3:0];
    wire ovf = serial_status_reg[6];
    irq_gate_a: assert property (ovf_irq == (ovf & ovf_int_enable))
        else $error("overflow request differs from flag and enable");
    start_gate_a: assert property (start_irq == (serial_status_reg[7] & start_int_enable))
        else $error("start request differs from flag and enable");
    status_load_a: assert property (status_wr && status_wdata[6] |=> !ovf && cnt == $past(status_wdata[3:0]))
        else $error("status write did not clear flag and load count");
    data_keep_a: assert property (data_wr |=> serial_shift_reg == $past(data_wdata))
        else $error("written data not kept");
    wrap_flag_a: assert property ($rose(ovf) |-> cnt == 4'h0 && $past(cnt) == 4'hf)
        else $error("flag set without counter wrap");
    count_step_a: assert property (!status_wr |=> cnt == $past(cnt) || cnt == $past(cnt) + 4'h1)
        else $error("counter moved by more than one");
    left_shift_a: assert property (!data_wr |=> serial_shift_reg == $past(serial_shift_reg)
        || serial_shift_reg[7:1] == $past(serial_shift_reg[6:0]))
        else $error("register changed other than by left shift");
    rx_push_a: assert property ($rose(ovf) |-> ##[1:3] rx_valid)
        else $error("byte not queued after overflow");
    edge_count_a: assert property (clock_source_select && $changed(serial_clock_pin_in) && !status_wr
        |-> ##[2:5] $changed(cnt))
        else $error("pin clock edge not counted");
    quiet_pin_a: assert property ((wire_mode_select != 2'h1) [*2] |-> !data_out_pin)
        else $error("data output driven outside three-wire mode");
    // main scenarios reached
    cover property ($rose(ovf));
    cover property (rx_valid && ovf_irq);
    cover property (data_wr && !clock_source_select);
endmodule // usi_shifter_sva

bind usi_shifter usi_shifter_sva u_sva (.core_clk(core_clk), .rst(rst),
    .wire_mode_select(wire_mode_select), .clock_source_select(clock_source_select),
    .ovf_int_enable(ovf_int_enable), .start_int_enable(start_int_enable), .data_wr(data_wr),
    .data_wdata(data_wdata), .serial_shift_reg(serial_shift_reg), .status_wr(status_wr),
    .status_wdata(status_wdata), .serial_status_reg(serial_status_reg), .ovf_irq(ovf_irq),
    .start_irq(start_irq), .rx_valid(rx_valid), .serial_clock_pin_in(serial_clock_pin_in),
    .data_out_pin(data_out_pin));

/* File: usi_spi_master_model.sv */
`timescale 1ns/1ns
// far-side master, clock idles low between frames
module usi_spi_master_model (
    input wire core_clk,
    input wire cpha,
    input wire miso,
    output reg sclk,
    output reg mosi
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
    end
    // one byte msb first, two toggles per bit, data set a half period early
    task automatic xfer(input [7:0] tx, output [7:0] rx);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            @(posedge core_clk);
            sclk <= cpha;
            mosi <= tx[i];
            repeat (4) @(posedge core_clk);
            sclk <= ~cpha;
            repeat (4) @(posedge core_clk);
            rx[i] = miso;
        end
        @(posedge core_clk);
        sclk <= 1'b0;
        mosi <= ~mosi; // released line shows no stale bit
    endtask
endmodule // usi_spi_master_model

/* File: usi_shifter_tb.sv */
`timescale 1ns/1ns
module usi_shifter_tb;
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg [1:0] wm = 2'h1;
    reg src = 1'b1, edge_sel = 1'b0, ctrl_wr = 1'b0, sw_stb = 1'b0, ovf_en = 1'b0, t0 = 1'b0;
    reg data_wr = 1'b0, status_wr = 1'b0, rx_ready = 1'b0, tgl = 1'b0;
    wire sck_out, ovr, wake;
    reg [7:0] wdata = 8'h00, swdata = 8'h00, got;
    wire [7:0] ssr, status, rx_data;
    wire ovf_irq, rx_valid, sclk, mosi, dout;
    integer errors = 0, n_checks = 0, cyc = 0, i, n;
    usi_shifter u_dut (.core_clk(core_clk), .rst(rst), .wire_mode_select(wm),
        .clock_source_select(src), .clock_edge_select(edge_sel), .ctrl_wr(ctrl_wr),
        .software_clock_strobe(sw_stb), .clock_toggle_strobe(tgl), .ovf_int_enable(ovf_en),
        .start_int_enable(1'b0), .timer0_compare_match(t0), .data_wr(data_wr),
        .data_wdata(wdata), .serial_shift_reg(ssr), .status_wr(status_wr),
        .status_wdata(swdata), .serial_status_reg(status), .ovf_irq(ovf_irq), .start_irq(),
        .idle_wake(wake), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_overrun(ovr), .serial_in_pin(mosi), .serial_clock_pin_in(sclk),
        .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(), .port_clock_level(1'b0),
        .port_clock_dir(1'b0), .sda_pin_in(1'b1), .data_out_pin(dout), .sda_pin_out(),
        .sda_pin_oe());
    usi_spi_master_model u_master (.core_clk(core_clk), .cpha(edge_sel), .miso(dout),
        .sclk(sclk), .mosi(mosi));
    // clock and cycle ceiling
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors = errors + 1;
            stop_test;
        end
    end
    task tick(input integer k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task put_data(input [7:0] v);
        @(posedge core_clk);
        data_wr <= 1'b1;
        wdata <= v;
        @(posedge core_clk);
        data_wr <= 1'b0;
    endtask
    task put_status(input [7:0] v);
        @(posedge core_clk);
        status_wr <= 1'b1;
        swdata <= v;
        @(posedge core_clk);
        status_wr <= 1'b0;
    endtask
    task strobe(input dw);
        @(posedge core_clk);
        ctrl_wr <= 1'b1;
        sw_stb <= 1'b1;
        data_wr <= dw;
        @(posedge core_clk);
        ctrl_wr <= 1'b0;
        sw_stb <= 1'b0;
        data_wr <= 1'b0;
    endtask
    task pop;
        @(posedge core_clk);
        rx_ready <= 1'b1;
        @(posedge core_clk);
        rx_ready <= 1'b0;
    endtask
    task cmp8(input [7:0] g, input [7:0] e);
        n_checks = n_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        tick(1);
        cmp8(ssr, 8'h00);
        cmp8(status, 8'h00);
        put_data(8'ha5);
        put_status(8'h40);
        u_master.xfer(8'h3c, got);
        tick(8);
        cmp8(ssr, 8'h3c);
        cmp8(got, 8'ha5);
        cmp8(status, 8'h40);
        cmp8({7'h0, ovf_irq}, 8'h00);
        @(posedge core_clk) ovf_en <= 1'b1;
        tick(1);
        cmp8({7'h0, ovf_irq}, 8'h01);
        cmp8({7'h0, wake}, 8'h01);
        cmp8(rx_data, 8'h3c);
        pop;
        @(posedge core_clk) edge_sel <= 1'b1;
        put_data(8'h00);
        put_status(8'h40);
        tick(1);
        cmp8({7'h0, ovf_irq}, 8'h00);
        u_master.xfer(8'h96, got);
        tick(8);
        cmp8(ssr, 8'h96);
        cmp8(status, 8'h40);
        pop;
        @(posedge core_clk) src <= 1'b0;
        wm <= 2'h0;
        tgl <= 1'b1;
        put_status(8'h4e);
        strobe(1'b0);
        tick(1);
        cmp8({7'h0, sck_out}, 8'h01);
        strobe(1'b0);
        tick(2);
        cmp8(status, 8'h40);
        cmp8({7'h0, sck_out}, 8'h00);
        cmp8({7'h0, dout}, 8'h00);
        wdata <= 8'h5a;
        strobe(1'b1);
        tick(1);
        cmp8(ssr, 8'h5a);
        @(posedge core_clk) edge_sel <= 1'b0;
        put_status(8'h40);
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge core_clk) t0 <= 1'b1;
            @(posedge core_clk) t0 <= 1'b0;
        end
        tick(2);
        cmp8(status, 8'h03);
        @(posedge core_clk) edge_sel <= 1'b1;
        for (i = 0; i < 34; i = i + 1) begin
            put_status(8'h4f);
            strobe(1'b0);
        end
        tick(3);
        cmp8(status, 8'h60);
        cmp8({7'h0, ovr}, 8'h01);
        n = 0;
        @(posedge core_clk) rx_ready <= 1'b1;
        repeat (40) begin
            @(posedge core_clk);
            if (rx_valid === 1'b1) n = n + 1;
        end
        cmp8(n[7:0], 8'h20);
        cmp8({7'h0, rx_valid}, 8'h00);
        stop_test;
    end
endmodule // usi_shifter_tb
